// File: cstx_linemem.sv
// Line buffer storage for all four receive channels
`timescale 1ns/1ns
module cstx_linemem
	import cstx_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic                   ce,
	input  wire logic                   we,
	input  wire logic [CSTX_MEM_AW-1:0] waddr,
	input  wire logic [CSTX_MEM_DW-1:0] wdata,
	input  wire logic                   re,
	input  wire logic [CSTX_MEM_AW-1:0] raddr,
	output logic      [CSTX_MEM_DW-1:0] rdata
);
	logic [CSTX_MEM_DW-1:0] mem [2**CSTX_MEM_AW];

	always_ff @(posedge clk) begin
		if (ce && we) begin
			mem[waddr] <= wdata;
		end
	end

	// Read word held until the next read
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata <= '0;
		end else if (ce && re) begin
			rdata <= mem[raddr];
		end
	end
endmodule

// File: cstx_output_path.sv
// Camera serial transmit output path: line buffers, forwarding, link lanes, status
`timescale 1ns/1ns
module cstx_output_path
	import cstx_pkg::*;
(
	input  wire logic       MCLK,
	input  wire logic       RSTN,
	input  wire logic       CE,
	input  wire logic [7:0] REG_ADDR,
	input  wire logic       REG_WE,
	input  wire logic [7:0] REG_WDATA,
	output logic      [7:0] REG_RDATA,
	input  wire logic       RX_VALID,
	output logic            RX_READY,
	input  wire logic [1:0] RX_CHAN,
	input  wire logic [7:0] RX_DATA,
	input  wire logic       RX_LAST,
	input  wire logic       RX_ERR,
	output logic      [1:0] LANE_RATE,
	output logic            TX_STATUS_GPIO,
	output logic            STATUS_CHANGE,
	input  wire logic       LINK_CLK,
	output logic            DL_HS_EN,
	output logic            DL_BYTE_VALID,
	output logic      [7:0] DL_DATA,
	output logic      [1:0] DL_LP,
	output logic            CL_HS_EN,
	output logic      [1:0] CL_LP
);
	import cstx_pkg::*;

	typedef enum {CSTX_EG_IDLE, CSTX_EG_ISSUE, CSTX_EG_PUSH} cstx_eg_e;
	typedef enum {CSTX_L_IDLE, CSTX_L_CKLPX, CSTX_L_CKPRE, CSTX_L_CKZER, CSTX_L_CKBEF,
		CSTX_L_LPX, CSTX_L_HSPRE, CSTX_L_HSZER, CSTX_L_SYNC, CSTX_L_DATA, CSTX_L_HSTRL,
		CSTX_L_CKPST, CSTX_L_CKTRL, CSTX_L_HSEXT} cstx_ln_e;

	// Ingress, buffers and egress
	logic [14:0] wptr_r [CSTX_CHANS], wptr_nxt [CSTX_CHANS];
	logic [14:0] rptr_r [CSTX_CHANS], rptr_nxt [CSTX_CHANS];
	logic [14:0] pkt_r  [CSTX_CHANS], pkt_nxt  [CSTX_CHANS];
	cstx_eg_e    eg_r, eg_nxt;
	logic [1:0]  sel_r, sel_nxt, cand, pick;
	logic        found, rx_take, eg_push, bi_ready, bo_valid, bo_ready;
	logic [8:0]  mem_rdata, bo_data;

	assign RX_READY = cstx_used(wptr_r[RX_CHAN], rptr_r[RX_CHAN]) != CSTX_BUF_BYTES;
	assign rx_take  = RX_VALID && RX_READY;
	assign eg_push  = eg_r == CSTX_EG_PUSH && bi_ready;

	always_comb begin
		wptr_nxt = wptr_r;
		rptr_nxt = rptr_r;
		eg_nxt   = eg_r;
		sel_nxt  = sel_r;
		found    = 1'b0;
		pick     = sel_r;
		cand     = sel_r;
		// Round robin over channels holding a whole packet
		for (int k = 1; k <= CSTX_CHANS; k++) begin
			cand = 2'(sel_r + 2'(k));
			if (!found && pkt_r[cand] != '0) begin
				found = 1'b1;
				pick  = cand;
			end
		end
		for (int i = 0; i < CSTX_CHANS; i++) begin
			pkt_nxt[i] = 15'(pkt_r[i] + {14'h0, rx_take && RX_LAST && RX_CHAN == 2'(i)}
				- {14'h0, eg_push && mem_rdata[8] && sel_r == 2'(i)});
		end
		if (rx_take) begin
			wptr_nxt[RX_CHAN] = 15'(wptr_r[RX_CHAN] + 15'h1);
		end
		case (eg_r)
			CSTX_EG_IDLE: begin
				if (found) begin
					sel_nxt = pick;
					eg_nxt  = CSTX_EG_ISSUE;
				end
			end
			CSTX_EG_ISSUE: begin
				rptr_nxt[sel_r] = 15'(rptr_r[sel_r] + 15'h1);
				eg_nxt          = CSTX_EG_PUSH;
			end
			CSTX_EG_PUSH: begin
				if (bi_ready) begin
					eg_nxt = mem_rdata[8] ? CSTX_EG_IDLE : CSTX_EG_ISSUE;
				end
			end
			default: eg_nxt = CSTX_EG_IDLE;
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			wptr_r <= '{default: '0};
			rptr_r <= '{default: '0};
			pkt_r  <= '{default: '0};
			eg_r   <= CSTX_EG_IDLE;
			sel_r  <= 2'h0;
		end else if (CE) begin
			wptr_r <= wptr_nxt;
			rptr_r <= rptr_nxt;
			pkt_r  <= pkt_nxt;
			eg_r   <= eg_nxt;
			sel_r  <= sel_nxt;
		end
	end

	cstx_linemem u_mem (
		.clk   (MCLK),
		.rst_n (RSTN),
		.ce    (CE),
		.we    (rx_take),
		.waddr ({RX_CHAN, wptr_r[RX_CHAN][CSTX_BUF_AW-1:0]}),
		.wdata ({RX_LAST, RX_DATA}),
		.re    (eg_r == CSTX_EG_ISSUE),
		.raddr ({sel_r, rptr_r[sel_r][CSTX_BUF_AW-1:0]}),
		.rdata (mem_rdata)
	);

	cstx_pair_buf #(.W(CSTX_MEM_DW)) u_buf (
		.clk       (MCLK),
		.rst_n     (RSTN),
		.ce        (CE),
		.in_valid  (eg_r == CSTX_EG_PUSH),
		.in_ready  (bi_ready),
		.in_data   (mem_rdata),
		.out_valid (bo_valid),
		.out_ready (bo_ready),
		.out_data  (bo_data)
	);

	// Header parse, line count and length, registers, status
	logic [1:0]  pos_r, pos_nxt, rate_r, rate_nxt, gsel_r, gsel_nxt, stat_r, stat_nxt;
	logic [7:0]  di_r, di_nxt, wcl_r, wcl_nxt, rd_nxt;
	logic [15:0] lcnt_r, lcnt_nxt, llen_r, llen_nxt;
	logic [11:0] idle_r, idle_nxt;
	logic        cmode_r, cmode_nxt, syen_r, syen_nxt, pass, gpio_nxt;

	always_comb begin
		pos_nxt   = pos_r;
		di_nxt    = di_r;
		wcl_nxt   = wcl_r;
		lcnt_nxt  = lcnt_r;
		llen_nxt  = llen_r;
		rate_nxt  = rate_r;
		cmode_nxt = cmode_r;
		syen_nxt  = syen_r;
		gsel_nxt  = gsel_r;
		idle_nxt  = idle_r;
		pass      = stat_r[CSTX_PASS_B];
		if (rx_take) begin
			pos_nxt = RX_LAST ? CSTX_POS_DI :
				(pos_r == CSTX_POS_BODY ? pos_r : 2'(pos_r + 2'h1));
			case (pos_r)
				CSTX_POS_DI: begin
					di_nxt = RX_DATA;
					if (RX_DATA[5:0] == CSTX_DT_FS) begin
						lcnt_nxt = '0;
					end
				end
				CSTX_POS_WCL: wcl_nxt = RX_DATA;
				CSTX_POS_WCH: begin
					if (di_r[5:0] >= CSTX_DT_LONG) begin
						llen_nxt = {RX_DATA, wcl_r};
						lcnt_nxt = 16'(lcnt_r + 16'h1);
					end
				end
				default: pos_nxt = pos_nxt;
			endcase
		end
		if (REG_WE) begin
			case (REG_ADDR)
				CSTX_A_RATE:    rate_nxt  = REG_WDATA[1:0];
				CSTX_A_CLKMODE: cmode_nxt = REG_WDATA[CSTX_CLKMODE_B];
				CSTX_A_FWD:     syen_nxt  = REG_WDATA[CSTX_SYNCEN_B];
				CSTX_A_GPIO:    gsel_nxt  = REG_WDATA[1:0];
				default:        rate_nxt  = rate_nxt;
			endcase
		end
		// Pass follows forwarding; error or idle timeout drops it
		if (RX_ERR) begin
			pass = 1'b0;
		end else if (eg_push) begin
			pass     = 1'b1;
			idle_nxt = '0;
		end else if (idle_r == CSTX_PASS_IDLE) begin
			pass = 1'b0;
		end else begin
			idle_nxt = 12'(idle_r + 12'h1);
		end
		stat_nxt = {syen_r && pass, pass};
		case (gsel_r)
			CSTX_GS_PASS: gpio_nxt = stat_r[CSTX_PASS_B];
			CSTX_GS_SYNC: gpio_nxt = stat_r[CSTX_SYNC_B];
			CSTX_GS_OFF:  gpio_nxt = 1'b0;
			default:      gpio_nxt = |stat_r;
		endcase
		case (REG_ADDR)
			CSTX_A_RATE:    rd_nxt = {6'h0, rate_r};
			CSTX_A_CLKMODE: rd_nxt = 8'({cmode_r, 1'b0});
			CSTX_A_FWD:     rd_nxt = {7'h0, syen_r};
			CSTX_A_GPIO:    rd_nxt = {6'h0, gsel_r};
			CSTX_A_STATUS:  rd_nxt = {6'h0, stat_r};
			CSTX_A_LCNT_HI: rd_nxt = lcnt_r[15:8];
			CSTX_A_LCNT_LO: rd_nxt = lcnt_r[7:0];
			CSTX_A_LLEN_HI: rd_nxt = llen_r[15:8];
			CSTX_A_LLEN_LO: rd_nxt = llen_r[7:0];
			default:        rd_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			pos_r <= CSTX_POS_DI;
			di_r <= 8'h00;
			wcl_r <= 8'h00;
			lcnt_r <= 16'h0000;
			llen_r <= 16'h0000;
			rate_r <= CSTX_RATE_RST;
			cmode_r <= 1'b0;
			syen_r <= 1'b0;
			gsel_r <= CSTX_GS_OFF;
			idle_r <= 12'h000;
			stat_r <= 2'h0;
			STATUS_CHANGE <= 1'b0;
			TX_STATUS_GPIO <= 1'b0;
			REG_RDATA <= 8'h00;
		end else if (CE) begin
			pos_r <= pos_nxt;
			di_r <= di_nxt;
			wcl_r <= wcl_nxt;
			lcnt_r <= lcnt_nxt;
			llen_r <= llen_nxt;
			rate_r <= rate_nxt;
			cmode_r <= cmode_nxt;
			syen_r <= syen_nxt;
			gsel_r <= gsel_nxt;
			idle_r <= idle_nxt;
			stat_r <= stat_nxt;
			STATUS_CHANGE <= stat_nxt != stat_r;
			TX_STATUS_GPIO <= gpio_nxt;
			REG_RDATA <= rd_nxt;
		end
	end
	assign LANE_RATE = rate_r;

	// Byte handshake toward the link domain
	logic [8:0] xfer_r;
	logic       req_r, pend_r, ack_s1, ack_s2, ack_r;
	assign bo_ready = !pend_r;
	always_ff @(posedge MCLK) begin
		ack_s1 <= ack_r;
		ack_s2 <= ack_s1;
		if (!RSTN) begin
			xfer_r <= 9'h000;
			req_r  <= 1'b0;
			pend_r <= 1'b0;
		end else if (CE) begin
			if (bo_valid && bo_ready) begin
				xfer_r <= bo_data;
				req_r  <= ~req_r;
				pend_r <= 1'b1;
			end else if (ack_s2 == req_r) begin
				pend_r <= 1'b0;
			end
		end
	end

	// Link domain
	logic       lrst_s1, lrst_s2, lce_s1, lce_s2, cm_s1, cm_s2, req_s1, req_s2;
	logic       hv_r, hv_nxt, ckon_r, ckon_nxt, lbit_r, lbit_nxt, take;
	logic [8:0] hd_r, hd_nxt;
	logic [7:0] cnt_r, cnt_nxt;
	cstx_ln_e   ls_r, ls_nxt;

	function automatic logic [7:0] cstx_dur(input cstx_ln_e s);
		case (s)
			CSTX_L_CKLPX, CSTX_L_LPX: return CSTX_C_LPX;
			CSTX_L_CKPRE: return CSTX_C_CKPRE;
			CSTX_L_CKZER: return CSTX_C_CKZER;
			CSTX_L_CKBEF: return CSTX_C_CKBEF;
			CSTX_L_HSPRE: return CSTX_C_HSPRE;
			CSTX_L_HSZER: return CSTX_C_HSZER;
			CSTX_L_HSTRL: return CSTX_C_HSTRL;
			CSTX_L_CKPST: return CSTX_C_CKPST;
			CSTX_L_CKTRL: return CSTX_C_CKTRL;
			CSTX_L_HSEXT: return CSTX_C_HSEXT;
			default:      return 8'h01;
		endcase
	endfunction

	always_comb begin
		ls_nxt   = ls_r;
		cnt_nxt  = cnt_r == 8'h00 ? cnt_r : 8'(cnt_r - 8'h01);
		ckon_nxt = ckon_r;
		lbit_nxt = lbit_r;
		take     = 1'b0;
		case (ls_r)
			CSTX_L_IDLE: begin
				if (hv_r || (cm_s2 && !ckon_r)) begin
					ls_nxt = ckon_r ? CSTX_L_LPX : CSTX_L_CKLPX;
				end
			end
			CSTX_L_CKLPX: if (cnt_r == 8'h00) ls_nxt = CSTX_L_CKPRE;
			CSTX_L_CKPRE: if (cnt_r == 8'h00) ls_nxt = CSTX_L_CKZER;
			CSTX_L_CKZER: if (cnt_r == 8'h00) ls_nxt = CSTX_L_CKBEF;
			CSTX_L_CKBEF: if (cnt_r == 8'h00) ls_nxt = hv_r ? CSTX_L_LPX : CSTX_L_IDLE;
			CSTX_L_LPX:   if (cnt_r == 8'h00) ls_nxt = CSTX_L_HSPRE;
			CSTX_L_HSPRE: if (cnt_r == 8'h00) ls_nxt = CSTX_L_HSZER;
			CSTX_L_HSZER: if (cnt_r == 8'h00) ls_nxt = CSTX_L_SYNC;
			CSTX_L_SYNC:  ls_nxt = CSTX_L_DATA;
			CSTX_L_DATA: begin
				if (hv_r) begin
					take     = 1'b1;
					lbit_nxt = hd_r[7];
					if (hd_r[8]) begin
						ls_nxt = CSTX_L_HSTRL;
					end
				end
			end
			CSTX_L_HSTRL: if (cnt_r == 8'h00) ls_nxt = cm_s2 ? CSTX_L_HSEXT : CSTX_L_CKPST;
			CSTX_L_CKPST: if (cnt_r == 8'h00) ls_nxt = CSTX_L_CKTRL;
			CSTX_L_CKTRL: if (cnt_r == 8'h00) ls_nxt = CSTX_L_HSEXT;
			CSTX_L_HSEXT: if (cnt_r == 8'h00) ls_nxt = CSTX_L_IDLE;
			default:      ls_nxt = CSTX_L_IDLE;
		endcase
		if (ls_nxt != ls_r) begin
			cnt_nxt = 8'(cstx_dur(ls_nxt) - 8'h01);
		end
		if (ls_nxt == CSTX_L_CKZER) begin
			ckon_nxt = 1'b1;
		end else if (ls_r == CSTX_L_CKTRL && ls_nxt == CSTX_L_HSEXT) begin
			ckon_nxt = 1'b0;
		end
		hv_nxt = hv_r && !take;
		hd_nxt = hd_r;
		if (!hv_nxt && req_s2 != ack_r) begin
			hv_nxt = 1'b1;
			hd_nxt = xfer_r;
		end
	end

	always_ff @(posedge LINK_CLK) begin
		lrst_s1 <= RSTN;
		lrst_s2 <= lrst_s1;
		lce_s1  <= CE;
		lce_s2  <= lce_s1;
		cm_s1   <= cmode_r;
		cm_s2   <= cm_s1;
		req_s1  <= req_r;
		req_s2  <= req_s1;
		if (!lrst_s2) begin
			ls_r <= CSTX_L_IDLE;
			cnt_r <= 8'h00;
			ckon_r <= 1'b0;
			lbit_r <= 1'b0;
			hv_r <= 1'b0;
			hd_r <= 9'h000;
			ack_r <= 1'b0;
			DL_HS_EN <= 1'b0;
			DL_BYTE_VALID <= 1'b0;
			DL_DATA <= 8'h00;
			DL_LP <= CSTX_LP11;
			CL_HS_EN <= 1'b0;
			CL_LP <= CSTX_LP11;
		end else if (lce_s2) begin
			ls_r <= ls_nxt;
			cnt_r <= cnt_nxt;
			ckon_r <= ckon_nxt;
			lbit_r <= lbit_nxt;
			hv_r <= hv_nxt;
			hd_r <= hd_nxt;
			if (!hv_r || take) begin
				ack_r <= req_s2;
			end
			DL_HS_EN <= ls_nxt inside {CSTX_L_HSZER, CSTX_L_SYNC, CSTX_L_DATA, CSTX_L_HSTRL};
			DL_BYTE_VALID <= take;
			DL_DATA <= ls_nxt == CSTX_L_SYNC ? CSTX_HS_SYNC : take ? hd_r[7:0] :
				ls_nxt == CSTX_L_HSTRL ? {8{~lbit_nxt}} : CSTX_HS_ZERO;
			DL_LP <= ls_nxt == CSTX_L_LPX ? CSTX_LP01 :
				(ls_nxt inside {CSTX_L_HSPRE, CSTX_L_HSZER, CSTX_L_SYNC, CSTX_L_DATA,
				CSTX_L_HSTRL}) ? CSTX_LP00 : CSTX_LP11;
			CL_HS_EN <= ckon_nxt;
			CL_LP <= ls_nxt == CSTX_L_CKLPX ? CSTX_LP01 :
				(ls_nxt == CSTX_L_CKPRE || ckon_nxt) ? CSTX_LP00 : CSTX_LP11;
		end
	end

	chk_buf_full: assert property (@(posedge MCLK) disable iff (!RSTN)
		rx_take |-> cstx_used(wptr_r[RX_CHAN], rptr_r[RX_CHAN]) < CSTX_BUF_BYTES)
		else $error("buffer accepted data while full");
	chk_whole_packet: assert property (@(posedge MCLK) disable iff (!RSTN || !CE)
		eg_r == CSTX_EG_IDLE && eg_nxt == CSTX_EG_ISSUE
		|-> pkt_r[pick] != '0 && cstx_used(wptr_r[pick], rptr_r[pick]) != '0)
		else $error("read started without a whole packet");
	chk_sync_zero: assert property (@(posedge MCLK) disable iff (!RSTN)
		!syen_r && $past(!syen_r) |-> !stat_r[CSTX_SYNC_B])
		else $error("sync status set while disabled");
	chk_line_restart: assert property (@(posedge MCLK) disable iff (!RSTN || !CE)
		rx_take && pos_r == CSTX_POS_DI && RX_DATA[5:0] == CSTX_DT_FS |=> lcnt_r == 16'h0000)
		else $error("line count not cleared at frame start");
	chk_len_capture: assert property (@(posedge MCLK) disable iff (!RSTN || !CE)
		rx_take && pos_r == CSTX_POS_WCH && di_r[5:0] >= CSTX_DT_LONG
		|=> llen_r == {$past(RX_DATA), $past(wcl_r)} && lcnt_r == 16'($past(lcnt_r) + 16'h1))
		else $error("line length or count not updated");
	chk_status_event: assert property (@(posedge MCLK) disable iff (!RSTN || !CE)
		STATUS_CHANGE == (stat_r != $past(stat_r)))
		else $error("status change event mismatch");
	chk_hs_entry: assert property (@(posedge LINK_CLK) disable iff (!lrst_s2 || !lce_s2)
		$rose(DL_HS_EN) |-> $past(DL_LP) == CSTX_LP00 && DL_DATA == CSTX_HS_ZERO)
		else $error("high speed entered without prepare");
	chk_clk_first: assert property (@(posedge LINK_CLK) disable iff (!lrst_s2 || !lce_s2)
		$rose(DL_HS_EN) |-> CL_HS_EN)
		else $error("data burst without running clock lane");
	chk_clk_hold: assert property (@(posedge LINK_CLK) disable iff (!lrst_s2 || !lce_s2)
		cm_s2 && $past(cm_s2) && CL_HS_EN |=> CL_HS_EN)
		else $error("continuous clock lane stopped");
endmodule

// File: cstx_pair_buf.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
module cstx_pair_buf #(
	parameter int W = 9
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         ce,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	logic [W-1:0] ent_r [2];
	logic [W-1:0] ent_nxt [2];
	logic         head_r, head_nxt;
	logic [1:0]   cnt_r, cnt_nxt;
	logic         push, pop;

	assign in_ready  = cnt_r != 2'h2;
	assign out_valid = cnt_r != 2'h0;
	assign out_data  = ent_r[head_r];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		ent_nxt  = ent_r;
		head_nxt = head_r;
		cnt_nxt  = cnt_r;
		if (push) begin
			ent_nxt[1'(head_r + cnt_r[0])] = in_data;
		end
		if (pop) begin
			head_nxt = ~head_r;
		end
		cnt_nxt = 2'(cnt_r + {1'b0, push} - {1'b0, pop});
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ent_r  <= '{default: '0};
			head_r <= 1'b0;
			cnt_r  <= 2'h0;
		end else if (ce) begin
			ent_r  <= ent_nxt;
			head_r <= head_nxt;
			cnt_r  <= cnt_nxt;
		end
	end
endmodule

// File: cstx_pkg.sv
// Shared constants for the camera transmit output path
package cstx_pkg;
	localparam int               CSTX_CHANS      = 4;
	localparam int               CSTX_MEM_AW     = 16;
	localparam int               CSTX_MEM_DW     = 9;
	localparam int               CSTX_BUF_AW     = 14;
	localparam logic [14:0]      CSTX_BUF_BYTES  = 15'h4000;
	localparam logic [7:0]       CSTX_A_RATE     = 8'h1F;
	localparam logic [7:0]       CSTX_A_FWD      = 8'h21;
	localparam logic [7:0]       CSTX_A_CLKMODE  = 8'h33;
	localparam logic [7:0]       CSTX_A_GPIO     = 8'h34;
	localparam logic [7:0]       CSTX_A_STATUS   = 8'h35;
	localparam logic [7:0]       CSTX_A_LCNT_HI  = 8'h73;
	localparam logic [7:0]       CSTX_A_LCNT_LO  = 8'h74;
	localparam logic [7:0]       CSTX_A_LLEN_HI  = 8'h75;
	localparam logic [7:0]       CSTX_A_LLEN_LO  = 8'h76;
	localparam int               CSTX_CLKMODE_B  = 1;
	localparam int               CSTX_SYNCEN_B   = 0;
	localparam int               CSTX_PASS_B     = 0;
	localparam int               CSTX_SYNC_B     = 1;
	localparam logic [1:0]       CSTX_RATE_RST   = 2'h0;
	localparam logic [1:0]       CSTX_GS_OFF     = 2'h0;
	localparam logic [1:0]       CSTX_GS_PASS    = 2'h1;
	localparam logic [1:0]       CSTX_GS_SYNC    = 2'h2;
	localparam logic [5:0]       CSTX_DT_FS      = 6'h00;
	localparam logic [5:0]       CSTX_DT_LONG    = 6'h10;
	localparam logic [1:0]       CSTX_POS_DI     = 2'h0;
	localparam logic [1:0]       CSTX_POS_WCL    = 2'h1;
	localparam logic [1:0]       CSTX_POS_WCH    = 2'h2;
	localparam logic [1:0]       CSTX_POS_BODY   = 2'h3;
	localparam logic [7:0]       CSTX_HS_SYNC    = 8'hB8;
	localparam logic [7:0]       CSTX_HS_ZERO    = 8'h00;
	localparam logic [1:0]       CSTX_LP11       = 2'h3;
	localparam logic [1:0]       CSTX_LP01       = 2'h1;
	localparam logic [1:0]       CSTX_LP00       = 2'h0;
	localparam int               CSTX_LINK_NS    = 6;
	localparam int               CSTX_T_LPX_NS   = 50;
	localparam int               CSTX_T_HSPRE_NS = 60;
	localparam int               CSTX_T_HSZER_NS = 150;
	localparam int               CSTX_T_HSTRL_NS = 60;
	localparam int               CSTX_T_HSEXT_NS = 100;
	localparam int               CSTX_T_CKPRE_NS = 38;
	localparam int               CSTX_T_CKZER_NS = 262;
	localparam int               CSTX_T_CKBEF_NS = 8;
	localparam int               CSTX_T_CKPST_NS = 60;
	localparam int               CSTX_T_CKTRL_NS = 60;
	localparam int               CSTX_MCLK_MHZ   = 25;
	localparam int               CSTX_T_IDLE_US  = 100;
	localparam logic [11:0]      CSTX_PASS_IDLE  = 12'(CSTX_T_IDLE_US * CSTX_MCLK_MHZ);

	// Least time in link cycles, rounded up, never below one
	function automatic logic [7:0] cstx_cycles(input int ns);
		int c;
		c = (ns + CSTX_LINK_NS - 1) / CSTX_LINK_NS;
		if (c < 1) begin
			c = 1;
		end
		return 8'(c);
	endfunction

	// Bytes held in one line buffer
	function automatic logic [14:0] cstx_used(input logic [14:0] w, input logic [14:0] r);
		return 15'(w - r);
	endfunction

	localparam logic [7:0]       CSTX_C_LPX      = cstx_cycles(CSTX_T_LPX_NS);
	localparam logic [7:0]       CSTX_C_HSPRE    = cstx_cycles(CSTX_T_HSPRE_NS);
	localparam logic [7:0]       CSTX_C_HSZER    = cstx_cycles(CSTX_T_HSZER_NS);
	localparam logic [7:0]       CSTX_C_HSTRL    = cstx_cycles(CSTX_T_HSTRL_NS);
	localparam logic [7:0]       CSTX_C_HSEXT    = cstx_cycles(CSTX_T_HSEXT_NS);
	localparam logic [7:0]       CSTX_C_CKPRE    = cstx_cycles(CSTX_T_CKPRE_NS);
	localparam logic [7:0]       CSTX_C_CKZER    = cstx_cycles(CSTX_T_CKZER_NS);
	localparam logic [7:0]       CSTX_C_CKBEF    = cstx_cycles(CSTX_T_CKBEF_NS);
	localparam logic [7:0]       CSTX_C_CKPST    = cstx_cycles(CSTX_T_CKPST_NS);
	localparam logic [7:0]       CSTX_C_CKTRL    = cstx_cycles(CSTX_T_CKTRL_NS);
endpackage

// File: cstx_rx_model.sv
// Downstream lane receiver model: counts bursts and bytes
`timescale 1ns/1ns
module cstx_rx_model (
	input wire logic       LINK_CLK,
	input wire logic       DL_HS_EN,
	input wire logic       DL_BYTE_VALID,
	input wire logic [7:0] DL_DATA,
	input wire logic [1:0] DL_LP
);
	int         n_bytes = 0;
	int         n_bursts = 0;
	int         n_bad = 0;
	logic [7:0] first_byte = 8'h00;
	logic       hs_q = 1'b0;
	logic       got = 1'b0;
	logic [1:0] lp_q = 2'h3;
	always @(posedge LINK_CLK) begin
		hs_q <= DL_HS_EN;
		lp_q <= DL_LP;
		if (DL_HS_EN && !hs_q) begin
			n_bursts <= n_bursts + 1;
			got <= 1'b0;
			// Burst entered only from the low-power bridge state
			if (lp_q !== 2'h0) begin
				n_bad <= n_bad + 1;
			end
		end
		if (DL_HS_EN && DL_BYTE_VALID) begin
			n_bytes <= n_bytes + 1;
			if (!got) begin
				first_byte <= DL_DATA;
			end
			got <= 1'b1;
		end
	end
endmodule

// File: test_cstx_output_path.sv
// Self-checking bench for the camera transmit output path
`timescale 1ns/1ns
module test_cstx_output_path;
	import cstx_pkg::*;
	logic        mclk, lclk, rstn, we, rxv, rxr, rxl, rxe, gpio, chg, hs, bv, ckhs, ce;
	logic [7:0]  addr, wd, rdat, rxd, dd, r8;
	logic [1:0]  ch, rate, dlp, clp;
	logic [15:0] v;
	logic [15:0] wc;
	int          seed = 57794;
	int          err_count = 0;
	int          n_tests = 0;
	int          n_chg = 0;
	int          n_chg0 = 0;
	int          sent = 0;
	cstx_output_path u_dut (.MCLK(mclk), .RSTN(rstn), .CE(ce), .REG_ADDR(addr), .REG_WE(we),
		.REG_WDATA(wd), .REG_RDATA(rdat), .RX_VALID(rxv), .RX_READY(rxr), .RX_CHAN(ch),
		.RX_DATA(rxd), .RX_LAST(rxl), .RX_ERR(rxe), .LANE_RATE(rate), .TX_STATUS_GPIO(gpio),
		.STATUS_CHANGE(chg), .LINK_CLK(lclk), .DL_HS_EN(hs), .DL_BYTE_VALID(bv),
		.DL_DATA(dd), .DL_LP(dlp), .CL_HS_EN(ckhs), .CL_LP(clp));
	cstx_rx_model u_rx (.LINK_CLK(lclk), .DL_HS_EN(hs), .DL_BYTE_VALID(bv), .DL_DATA(dd),
		.DL_LP(dlp));
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	initial begin
		lclk = 1'b0;
		#7;
		forever #3 lclk = ~lclk;
	end
	always @(posedge mclk) begin
		if (chg === 1'b1) begin
			n_chg <= n_chg + 1;
		end
	end
	task automatic results();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// Identifier byte: channel on top, data type below
	function automatic logic [7:0] exp_id(input logic [1:0] c, input logic [5:0] dt);
		return {c, dt};
	endfunction
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wd <= d;
		we <= 1'b1;
		@(posedge mclk);
		we <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		repeat (3) @(posedge mclk);
		d = rdat;
	endtask
	task automatic rd16(input logic [7:0] a, output logic [15:0] d);
		logic [7:0] h;
		logic [7:0] l;
		rd(a, h);
		rd(a + 8'h01, l);
		d = {h, l};
	endtask
	task automatic put(input logic [1:0] c, input logic [7:0] b, input logic l);
		int k;
		ch <= c;
		rxd <= b;
		rxl <= l;
		rxv <= 1'b1;
		k = 0;
		@(posedge mclk);
		while (rxr !== 1'b1 && k < 100) begin
			k++;
			@(posedge mclk);
		end
	endtask
	// Header: identifier, count low, count high, ECC; long ones add payload and checksum
	task automatic pkt(input logic [1:0] c, input logic [5:0] dt, input logic [15:0] n,
		input bit hold);
		int len;
		logic [7:0] b;
		len = (dt >= CSTX_DT_LONG) ? n + 6 : 4;
		@(posedge mclk);
		for (int i = 0; i < len; i++) begin
			b = 8'($random(seed));
			if (i == 0) b = exp_id(c, dt);
			if (i == 1) b = n[7:0];
			if (i == 2) b = n[15:8];
			if (hold && i == len - 1) begin
				rxv <= 1'b0;
				repeat (200) @(posedge mclk);
				chk(16'(u_rx.n_bytes - sent), 16'h0000);
			end
			put(c, b, i == len - 1);
		end
		rxv <= 1'b0;
		sent += len;
	endtask
	task automatic drain();
		int k;
		k = 0;
		while ((u_rx.n_bytes < sent || dlp !== CSTX_LP11) && k < 70000) begin
			k++;
			@(posedge mclk);
		end
		repeat (20) @(posedge mclk);
		chk(16'(u_rx.n_bytes - sent), 16'h0000);
	endtask
	initial begin
		repeat (90000) @(posedge mclk);
		err_count++;
		results();
	end
	initial begin
		rstn = 1'b0;
		we = 1'b0;
		addr = 8'h00;
		wd = 8'h00;
		rxv = 1'b0;
		ch = 2'h0;
		rxd = 8'h00;
		rxl = 1'b0;
		rxe = 1'b0;
		ce = 1'b1;
		repeat (6) @(posedge mclk);
		rstn <= 1'b1;
		wr(CSTX_A_LCNT_HI, 8'h5A);
		wr(8'h50, 8'hA5);
		rd16(CSTX_A_LCNT_HI, v);
		chk(v, 16'h0000);
		rd(8'h50, r8);
		chk(16'(r8), 16'h0000);
		rd(CSTX_A_STATUS, r8);
		chk(16'(r8), 16'h0000);
		for (int r = 0; r < 4; r++) begin
			wr(CSTX_A_RATE, 8'(r));
			@(posedge mclk);
			chk(16'(rate), 16'(r));
		end
		$display("test registers done");
		wr(CSTX_A_GPIO, 8'h01);
		pkt(2'h0, CSTX_DT_FS, 16'h0000, 0);
		for (int c = 0; c < 4; c++) begin
			wc = 16'h0004 + 16'($random(seed) & 15);
			pkt(2'(c), 6'h2C, wc, 0);
		end
		drain();
		rd16(CSTX_A_LCNT_HI, v);
		chk(v, 16'h0004);
		rd16(CSTX_A_LLEN_HI, v);
		chk(v, wc);
		chk(16'(u_rx.n_bursts), 16'h0005);
		chk(16'(u_rx.first_byte), 16'(exp_id(2'h3, 6'h2C)));
		chk(16'(ckhs), 16'h0000);
		chk(16'(clp), 16'(CSTX_LP11));
		rd(CSTX_A_STATUS, r8);
		chk(16'(r8), 16'h0001);
		chk(16'(gpio), 16'h0001);
		chk(16'(n_chg != 0), 16'h0001);
		n_chg0 = n_chg;
		@(posedge mclk);
		rxe <= 1'b1;
		@(posedge mclk);
		rxe <= 1'b0;
		rd(CSTX_A_STATUS, r8);
		chk(16'(r8), 16'h0000);
		chk(16'(n_chg - n_chg0), 16'h0001);
		// Write while frozen must not land
		ce <= 1'b0;
		wr(CSTX_A_GPIO, 8'h03);
		@(posedge mclk);
		ce <= 1'b1;
		rd(CSTX_A_GPIO, r8);
		chk(16'(r8), 16'h0001);
		$display("test gated clock done");
		wr(CSTX_A_FWD, 8'h01);
		wr(CSTX_A_CLKMODE, 8'h02);
		wr(CSTX_A_GPIO, 8'h02);
		pkt(2'h2, 6'h12, 16'h0008, 0);
		drain();
		chk(16'(ckhs), 16'h0001);
		rd(CSTX_A_STATUS, r8);
		chk(16'(r8), 16'h0003);
		chk(16'(gpio), 16'h0001);
		wr(CSTX_A_GPIO, 8'h03);
		repeat (2) @(posedge mclk);
		chk(16'(gpio), 16'h0001);
		pkt(2'h1, CSTX_DT_FS, 16'h0000, 0);
		drain();
		rd16(CSTX_A_LCNT_HI, v);
		chk(v, 16'h0000);
		$display("test continuous clock done");
		pkt(2'h1, 6'h2C, 16'h3FFA, 1);
		#1;
		chk(16'(rxr), 16'h0000);
		drain();
		chk(16'(rxr), 16'h0001);
		rd16(CSTX_A_LLEN_HI, v);
		chk(v, 16'h3FFA);
		chk(16'(u_rx.n_bad), 16'h0000);
		$display("test full buffer done");
		results();
	end
endmodule
